// File: design/tft_panel_timing_generator.sv
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "tft_defines.svh"

module tft_panel_timing_generator #(
  parameter int CNT_W    = 13,
  parameter int DLY_TAPS = 15
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite write
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // pixel source
  input  wire tft_pkg::tft_rgb_t    pixel_in,
  output logic                      pixel_take,
  // panel pins
  output tft_pkg::tft_panel_t       panel_out
);
  import tft_pkg::*;

  // ----------------------------------------------------------------
  // registers and bus state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg, pol_reg, size_reg, htim_reg, vtim_reg, clkdiv_reg;
  logic        aw_full_reg, w_full_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;
  logic        wr_hit;
  logic [31:0] rd_mux;
  logic [1:0]  rd_resp;

  // ----------------------------------------------------------------
  // timing state
  // ----------------------------------------------------------------
  logic [`TFT_DIV_W-1:0] div_cnt_reg;
  logic                  pclk_raw_reg, pclk_next, pix_en, tap;
  logic [DLY_TAPS-1:0]   chain_reg;
  logic                  run_reg;
  logic [CNT_W-1:0]      hcnt_reg, vcnt_reg, h_nx, v_nx;
  logic [CNT_W-1:0]      hpw, hbp, hfp, hx, vpw, vbp, vfp, vy, h_total, v_total;
  tft_phase_t            h_ph, v_ph;
  logic                  h_sync_nx, v_sync_nx, show_nx;
  logic                  enable;

  // merge a write under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = dat[i*8 +: 8];
    end
    return res;
  endfunction

  // phase of a counter from its sync, back porch and visible lengths
  function automatic tft_phase_t phase_of(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] pw,
                                         input logic [CNT_W-1:0] bp, input logic [CNT_W-1:0] vis);
    tft_phase_t ph;
    ph = TFT_FRONT;
    if (c < pw)
      ph = TFT_SYNC;
    else if (c < pw + bp)
      ph = TFT_BACK;
    else if (c < pw + bp + vis)
      ph = TFT_SHOW;
    return ph;
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are caught independently so either may come first
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_hit        = (aw_addr_reg == `TFT_OFF_CTRL) || (aw_addr_reg == `TFT_OFF_POL)
                      || (aw_addr_reg == `TFT_OFF_SIZE) || (aw_addr_reg == `TFT_OFF_HTIM)
                      || (aw_addr_reg == `TFT_OFF_VTIM) || (aw_addr_reg == `TFT_OFF_CLKDIV);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TFT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `TFT_RESP_OKAY : `TFT_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg   <= `TFT_RST_CTRL;
      pol_reg    <= `TFT_RST_POL;   // active-high default
      size_reg   <= `TFT_RST_SIZE;
      htim_reg   <= `TFT_RST_TIM;
      vtim_reg   <= `TFT_RST_TIM;
      clkdiv_reg <= `TFT_RST_CLKDIV;
    end
    else if (do_write)
    begin
      if (aw_addr_reg == `TFT_OFF_CTRL)
        ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == `TFT_OFF_POL)
        pol_reg <= merge(pol_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == `TFT_OFF_SIZE)
        size_reg <= merge(size_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == `TFT_OFF_HTIM)
        htim_reg <= merge(htim_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == `TFT_OFF_VTIM)
        vtim_reg <= merge(vtim_reg, w_data_reg, w_strb_reg);
      else if (aw_addr_reg == `TFT_OFF_CLKDIV)
        clkdiv_reg <= merge(clkdiv_reg, w_data_reg, w_strb_reg);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // unmapped reads return zero with slave error
  always_comb
  begin
    rd_mux  = 32'h0000_0000;
    rd_resp = `TFT_RESP_OKAY;
    if (s_axi_araddr[7:2] == `TFT_OFF_CTRL >> 2)
      rd_mux = ctrl_reg;
    else if (s_axi_araddr[7:2] == `TFT_OFF_POL >> 2)
      rd_mux = pol_reg;
    else if (s_axi_araddr[7:2] == `TFT_OFF_SIZE >> 2)
      rd_mux = size_reg;
    else if (s_axi_araddr[7:2] == `TFT_OFF_HTIM >> 2)
      rd_mux = htim_reg;
    else if (s_axi_araddr[7:2] == `TFT_OFF_VTIM >> 2)
      rd_mux = vtim_reg;
    else if (s_axi_araddr[7:2] == `TFT_OFF_CLKDIV >> 2)
      rd_mux = clkdiv_reg;
    else if (s_axi_araddr[7:2] == `TFT_OFF_STATUS >> 2)
    begin
      rd_mux[`TFT_STAT_H_LSB +: CNT_W]  = hcnt_reg;
      rd_mux[`TFT_STAT_V_LSB +: CNT_W]  = vcnt_reg;
      rd_mux[`TFT_STAT_RUN_BIT]         = run_reg;
    end
    else
      rd_resp = `TFT_RESP_SLVERR;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TFT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_resp;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // pixel clock divider
  // ----------------------------------------------------------------
  assign enable = ctrl_reg[`TFT_CTRL_EN_BIT];

  // half period is divider plus one system clocks
  // at least two system clocks per period, far above 6.66 ns
  assign pclk_next = (div_cnt_reg == clkdiv_reg[`TFT_DIV_LSB +: `TFT_DIV_W]) ? !pclk_raw_reg
                                                                              : pclk_raw_reg;
  assign pix_en    = enable && !pclk_raw_reg && pclk_next;

  // free-running while enabled, parked low only when disabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable)
    begin
      div_cnt_reg  <= '0;
      pclk_raw_reg <= 1'b0;
    end
    else
    begin
      pclk_raw_reg <= pclk_next;
      if (div_cnt_reg == clkdiv_reg[`TFT_DIV_LSB +: `TFT_DIV_W])
        div_cnt_reg <= '0;
      else
        div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  // delay chain; tap 0 is undelayed so the edge lines up with data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      chain_reg <= '0;
    else
      chain_reg <= {chain_reg[DLY_TAPS-2:0], pclk_next && enable};
  end

  // delay select of the panel clock; inversion follows at the pin
  always_comb
  begin
    tap = pclk_next && enable;
    if (clkdiv_reg[`TFT_DLY_LSB +: `TFT_DLY_W] != '0)
      tap = chain_reg[clkdiv_reg[`TFT_DLY_LSB +: `TFT_DLY_W] - 1'b1];
  end

  // ----------------------------------------------------------------
  // line and frame counters
  // ----------------------------------------------------------------
  // zero sync width is stretched to one unit
  assign hpw = CNT_W'(htim_reg[`TFT_TIM_PW_LSB +: `TFT_TIM_W] == '0 ? 1
                      : htim_reg[`TFT_TIM_PW_LSB +: `TFT_TIM_W]);
  assign hbp = CNT_W'(htim_reg[`TFT_TIM_BP_LSB +: `TFT_TIM_W]);
  assign hfp = CNT_W'(htim_reg[`TFT_TIM_FP_LSB +: `TFT_TIM_W]);
  assign hx  = CNT_W'(size_reg[`TFT_SIZE_X_LSB +: `TFT_SIZE_W]);
  assign vpw = CNT_W'(vtim_reg[`TFT_TIM_PW_LSB +: `TFT_TIM_W] == '0 ? 1
                      : vtim_reg[`TFT_TIM_PW_LSB +: `TFT_TIM_W]);
  assign vbp = CNT_W'(vtim_reg[`TFT_TIM_BP_LSB +: `TFT_TIM_W]);
  assign vfp = CNT_W'(vtim_reg[`TFT_TIM_FP_LSB +: `TFT_TIM_W]);
  assign vy  = CNT_W'(size_reg[`TFT_SIZE_Y_LSB +: `TFT_SIZE_W]);

  // period is the sum of the four parts
  assign h_total = hpw + hbp + hfp + hx;
  assign v_total = vpw + vbp + vfp + vy;

  // first pixel clock after enable shows position zero, not one
  always_comb
  begin
    h_nx = '0;
    v_nx = '0;
    if (run_reg)
    begin
      if (hcnt_reg >= h_total - 1'b1)
      begin
        if (vcnt_reg < v_total - 1'b1)
          v_nx = vcnt_reg + 1'b1;
      end
      else
      begin
        h_nx = hcnt_reg + 1'b1;
        v_nx = vcnt_reg;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable)
    begin
      run_reg  <= 1'b0;
      hcnt_reg <= '0;
      vcnt_reg <= '0;
    end
    else if (pix_en)
    begin
      run_reg  <= 1'b1;
      hcnt_reg <= h_nx;
      vcnt_reg <= v_nx;
    end
  end

  // sync, back porch, visible, front porch
  assign h_ph = phase_of(h_nx, hpw, hbp, hx);
  assign v_ph = phase_of(v_nx, vpw, vbp, vy);

  always_comb
  begin
    h_sync_nx = 1'b0;
    v_sync_nx = 1'b0;
    show_nx   = 1'b0;
    case (h_ph)
      TFT_SYNC: h_sync_nx = 1'b1;
      TFT_SHOW: show_nx   = (v_ph == TFT_SHOW);   // visible in both axes
      default:  show_nx   = 1'b0;
    endcase
    case (v_ph)
      TFT_SYNC: v_sync_nx = 1'b1;                 // covers whole lines
      default:  v_sync_nx = 1'b0;
    endcase
  end

  // source pixel consumed only when it is shown
  assign pixel_take = pix_en && show_nx;

  // ----------------------------------------------------------------
  // panel outputs
  // ----------------------------------------------------------------
  // all updated at the edge where the raw clock rises
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      panel_out.hsync              <= 1'b0;
      panel_out.vsync              <= 1'b0;
      panel_out.pixel_valid_strobe <= 1'b0;
      panel_out.pixel_bus          <= '0;
    end
    else if (!enable)
    begin
      panel_out.hsync              <= pol_reg[`TFT_POL_H_BIT];
      panel_out.vsync              <= pol_reg[`TFT_POL_V_BIT];
      panel_out.pixel_valid_strobe <= 1'b0;
      panel_out.pixel_bus          <= '0;
    end
    else if (pix_en)
    begin
      panel_out.hsync              <= h_sync_nx ^ pol_reg[`TFT_POL_H_BIT];
      panel_out.vsync              <= v_sync_nx ^ pol_reg[`TFT_POL_V_BIT];
      panel_out.pixel_valid_strobe <= show_nx;
      // blank data outside the visible area
      panel_out.pixel_bus          <= show_nx ? pixel_in : '0;
    end
  end

  // clock pin; inversion applies only while enabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      panel_out.pixel_clk <= 1'b0;
    else
      panel_out.pixel_clk <= tap ^ (enable && clkdiv_reg[`TFT_INV_BIT]);
  end

endmodule // tft_panel_timing_generator

// File: shared/tft_defines.svh
`ifndef TFT_DEFINES_SVH
`define TFT_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TFT_OFF_CTRL     8'h00
`define TFT_OFF_POL      8'h04
`define TFT_OFF_SIZE     8'h08
`define TFT_OFF_HTIM     8'h0c
`define TFT_OFF_VTIM     8'h10
`define TFT_OFF_CLKDIV   8'h14
`define TFT_OFF_STATUS   8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TFT_CTRL_EN_BIT  0
`define TFT_POL_H_BIT    0
`define TFT_POL_V_BIT    1
`define TFT_TIM_W        10
`define TFT_TIM_PW_LSB   0
`define TFT_TIM_BP_LSB   10
`define TFT_TIM_FP_LSB   20
`define TFT_SIZE_W       12
`define TFT_SIZE_X_LSB   0
`define TFT_SIZE_Y_LSB   16
`define TFT_DIV_W        8
`define TFT_DIV_LSB      0
`define TFT_INV_BIT      8
`define TFT_DLY_W        4
`define TFT_DLY_LSB      9
`define TFT_STAT_H_LSB   0
`define TFT_STAT_V_LSB   16
`define TFT_STAT_RUN_BIT 31

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define TFT_RST_CTRL     32'h0000_0000
`define TFT_RST_POL      32'h0000_0000
`define TFT_RST_SIZE     32'h0000_0000
`define TFT_RST_TIM      32'h0000_0000
`define TFT_RST_CLKDIV   32'h0000_0000
`define TFT_RESP_OKAY    2'b00
`define TFT_RESP_SLVERR  2'b10

`endif

// File: shared/tft_pkg.sv
package tft_pkg;

  // one pixel, three 8-bit components
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } tft_rgb_t;

  // everything that goes to the panel
  typedef struct packed {
    logic     pixel_clk;
    logic     hsync;
    logic     vsync;
    logic     pixel_valid_strobe;
    tft_rgb_t pixel_bus;
  } tft_panel_t;

  // position of a counter within its line or frame
  typedef enum logic [1:0] {
    TFT_SYNC  = 2'b00,
    TFT_BACK  = 2'b01,
    TFT_SHOW  = 2'b10,
    TFT_FRONT = 2'b11
  } tft_phase_t;

endpackage

// File: bench/tft_panel_monitor.sv
`timescale 1ns/100ps
module tft_panel_monitor (
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // register bus handshakes
  input wire logic                s_axi_awready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  // pixel path and panel pins
  input wire tft_pkg::tft_rgb_t   pixel_in,
  input wire logic                pixel_take,
  input wire tft_pkg::tft_panel_t panel_out
);
  import tft_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------
  // panel timing
  // ------------
  a_reset_quiet:
    assert property (disable iff (1'b0) !aresetn |=> panel_out == '0)
    else $error("panel pins not cleared by reset");
  a_take_strobe:
    assert property (pixel_take |=> panel_out.pixel_valid_strobe)
    else $error("strobe low after pixel take");
  a_take_data:
    assert property (pixel_take |=> panel_out.pixel_bus == $past(pixel_in))
    else $error("pixel bus differs from taken pixel");
  a_strobe_cause:
    assert property ($rose(panel_out.pixel_valid_strobe) |-> $past(pixel_take))
    else $error("strobe rose without pixel take");
  a_take_clk:
    assert property (pixel_take |=> $changed(panel_out.pixel_clk))
    else $error("pixel clock did not switch with data");
  a_take_gap:
    assert property (pixel_take |=> !pixel_take)
    else $error("pixels taken closer than one pixel period");
  // slowest divider gives a half period of 256 cycles
  a_clk_run:
    assert property ($rose(panel_out.pixel_clk) |-> ##[1:256] $fell(panel_out.pixel_clk))
    else $error("pixel clock stalled high");
  // ------------
  // register bus
  // ------------
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before accepted");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before accepted");
  a_aw_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while answer pending");
  a_ar_refuse:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
endmodule // tft_panel_monitor

bind tft_panel_timing_generator tft_panel_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pixel_in(pixel_in), .pixel_take(pixel_take),
  .panel_out(panel_out));

// File: bench/tft_panel_model.sv
`timescale 1ns/100ps
module tft_panel_model (
  // clock and panel pins
  input wire logic                aclk,
  input wire tft_pkg::tft_panel_t panel_out,
  // polarity in use: bit0 line, bit1 frame, 1 = active low
  input wire logic [1:0]          pol,
  // captured pixel and last measured shape
  output logic                    cap_valid,
  output tft_pkg::tft_rgb_t       cap_pix,
  output logic [5:0][15:0]        stat
);
  import tft_pkg::*;
  logic        clk_q = 1'b0, hs_q = 1'b0, vs_q = 1'b0;
  logic [15:0] hc = 16'h0000, hw = 16'h0000, pc = 16'h0000;
  logic [15:0] lc = 16'h0000, vw = 16'h0000, vl = 16'h0000;
  logic        hs, vs;
  assign hs = panel_out.hsync ^ pol[0];
  assign vs = panel_out.vsync ^ pol[1];
  // panel acts on rising pixel clock only; stats are one line or frame late
  always @(posedge aclk)
  begin
    cap_valid <= 1'b0;
    clk_q <= panel_out.pixel_clk;
    if (panel_out.pixel_clk && !clk_q)
    begin
      if (panel_out.pixel_valid_strobe)
      begin
        cap_valid <= 1'b1;
        cap_pix <= panel_out.pixel_bus;
      end
      if (hs && !hs_q)
      begin
        // keep the shape of the last visible line; porch lines carry no pixels
        if (pc != 0)
          stat[2:0] = {pc, hw, hc};
        vl = vl + (pc != 0);
        if (vs && !vs_q)
        begin
          stat[5:3] = {vl, vw, lc};
          {lc, vw, vl} = '0;
        end
        lc = lc + 1'b1;
        vw = vw + vs;
        vs_q = vs;
        {hc, hw, pc} = '0;
      end
      hc = hc + 1'b1;
      hw = hw + hs;
      pc = pc + panel_out.pixel_valid_strobe;
      hs_q = hs;
    end
  end
endmodule // tft_panel_model

// File: bench/tb_top.sv
`timescale 1ns/100ps
`include "tft_defines.svh"
module tb_top;
  import tft_pkg::*;
  // -----------
  // bench state
  // -----------
  logic             aclk = 1'b0, aresetn = 1'b0, inv = 1'b0;
  logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]      wdata = 32'h0000_0000, rdata, lf = 32'hdff19e99;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic             rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic             pixel_take, cap_valid;
  logic [1:0]       bresp, rresp, pol = 2'b00;
  logic [33:0]      r;
  logic [5:0][15:0] stat;
  tft_rgb_t         pixel_in = 24'h000000, cap_pix;
  tft_panel_t       panel_out;
  logic [1:0]       bq[$];
  logic [33:0]      rq[$];
  tft_rgb_t         pq[$];
  int               fails = 0, total_checks = 0;
  // polarity, divider, invert, line pw bp x fp, frame pw bp y fp
  int cfg [4][11] = '{'{0, 0, 0, 2, 3, 4, 2, 2, 1, 3, 1}, '{1, 1, 1, 1, 1, 5, 1, 1, 2, 2, 1},
                      '{2, 0, 0, 3, 2, 3, 4, 1, 1, 4, 2}, '{3, 2, 0, 1, 2, 6, 3, 3, 2, 2, 1}};

  // 20 MHz clock
  always #25 aclk = ~aclk;

  tft_panel_timing_generator dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pixel_in(pixel_in), .pixel_take(pixel_take), .panel_out(panel_out));

  tft_panel_model pm_u (
    .aclk(aclk), .panel_out(panel_out), .pol(pol),
    .cap_valid(cap_valid), .cap_pix(cap_pix), .stat(stat));

  // -----------
  // tasks
  // -----------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // ready is sampled at the falling edge: it cannot move before the next rise
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw, tb, td;
    bq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      td = bvalid & bready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= tb & ~td;
    end while (!td);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tv, td;
    rq.push_back({e, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = arvalid & arready;
      tv = rvalid;
      td = rvalid & rready;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      rready <= tv & ~td;
    end while (!td);
  endtask

  task automatic run_cfg(input int i);
    int c[11];
    int sh, sv;
    c = cfg[i];
    sh = c[3] + c[4] + c[5] + c[6];
    sv = c[7] + c[8] + c[9] + c[10];
    pol = c[0][1:0];
    inv = c[2][0];
    axw(`TFT_OFF_POL, c[0], `TFT_RESP_OKAY);
    axw(`TFT_OFF_CLKDIV, c[1] | (c[2] << 8), `TFT_RESP_OKAY);
    axw(`TFT_OFF_HTIM, c[3] | (c[4] << 10) | (c[6] << 20), `TFT_RESP_OKAY);
    axr(`TFT_OFF_HTIM, c[3] | (c[4] << 10) | (c[6] << 20), `TFT_RESP_OKAY);
    axw(`TFT_OFF_VTIM, c[7] | (c[8] << 10) | (c[10] << 20), `TFT_RESP_OKAY);
    axw(`TFT_OFF_SIZE, c[5] | (c[9] << 16), `TFT_RESP_OKAY);
    chk("idle syncs", {pol[0], pol[1]}, {panel_out.hsync, panel_out.vsync});
    chk("idle strobe", 1'b0, panel_out.pixel_valid_strobe);
    axw(`TFT_OFF_CTRL, 32'h1, `TFT_RESP_OKAY);
    // three frames, so the model holds a full clean frame
    repeat (6 * sh * sv * (c[1] + 1)) @(posedge aclk);
    chk("line clocks", sh, stat[0]);
    chk("hsync clocks", c[3], stat[1]);
    chk("visible pixels", c[5], stat[2]);
    chk("frame lines", sv, stat[3]);
    chk("vsync lines", c[7], stat[4]);
    chk("visible lines", c[9], stat[5]);
    axw(`TFT_OFF_CTRL, 32'h0, `TFT_RESP_OKAY);
    $display("test %0d done", i);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // -----------
  // processes
  // -----------
  // answers and captured pixels against the oldest note
  always @(negedge aclk)
  begin
    if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
    if (rvalid && rready)
    begin
      r = rq.pop_front();
      chk("rdata", r[31:0], rdata);
      chk("rresp", r[33:32], rresp);
    end
    if (cap_valid) chk("pixel", pq.pop_front(), cap_pix);
  end

  // pixel source: random pixel ready whenever one is taken
  always @(negedge aclk)
    if (pixel_take === 1'b1)
    begin
      pq.push_back(pixel_in);
      chk("pixel_clk", inv, panel_out.pixel_clk);
      @(posedge aclk);
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      pixel_in <= lf[23:0];
    end

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`TFT_OFF_POL, 32'h0, `TFT_RESP_OKAY);
    chk("reset syncs", 2'b00, {panel_out.hsync, panel_out.vsync});
    axr(8'h1c, 32'h0, `TFT_RESP_SLVERR);
    axw(`TFT_OFF_STATUS, 32'h1, `TFT_RESP_SLVERR);
    for (int i = 0; i < 4; i++) run_cfg(i);
    end_of_test();
  end

  // watchdog well beyond the roughly 3500 cycles of the run
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    $display("Error watchdog expected finish seen hang");
    end_of_test();
  end
endmodule // tb_top
